//--- serial_port_zero.v
// Serial port zero: control/status registers, transmitter and receiver, APB slave
//
// Operation
// - A frame is received and its byte latched only while the receiver enable bit is 1.
// - In modes 2 and 3 the ninth bit sent is the ninth_tx_bit value at the time the byte is written.
// - In modes 0 and 1 the ninth_tx_bit value has no effect on the frame.
// - The rx_complete_flag is set when a byte is received, qualified by multiproc_stop_check.
// - With the interrupt enabled, a set rx_complete_flag raises the interrupt request.
// - In mode 1 with multiproc_stop_check at 1, rx_complete_flag rises only on a high stop bit.
// - An invalid stop bit in a received frame sets frame_error_flag.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_zero #(
    parameter DIV_WIDTH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rxd,
    output reg txd,
    output reg irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DATA = 3'b010;
    localparam ST_STOP = 3'b100;

    reg [7:0] serial_control;
    reg [7:0] serial_status_clock_select;
    reg [DIV_WIDTH-1:0] divisor;
    reg [`IRQ_BITS-1:0] irq_status;
    reg [`IRQ_BITS-1:0] irq_enable;
    reg [7:0] tx_data;

    wire [1:0] mode = serial_control[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire nine_bit = mode[1];
    wire [3:0] frame_bits = nine_bit ? 4'd9 : 4'd8;

    // APB: zero wait states, so the answer comes in the access phase
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire wr_ctrl = wr && (paddr == `SP_CTRL_ADDR);
    wire wr_stat = wr && (paddr == `SP_STAT_ADDR);
    wire wr_data = wr && (paddr == `SP_DATA_ADDR);
    wire wr_div = wr && (paddr == `SP_DIVISOR_ADDR);
    wire wr_ien = wr && (paddr == `SP_IRQ_ENABLE_ADDR);
    wire wr_iclr = wr && (paddr == `SP_IRQ_CLEAR_ADDR);
    wire rd_data = rd && (paddr == `SP_DATA_ADDR);
    wire mapped = (paddr == `SP_CTRL_ADDR) || (paddr == `SP_STAT_ADDR) ||
                  (paddr == `SP_DATA_ADDR) || (paddr == `SP_DIVISOR_ADDR) ||
                  (paddr == `SP_IRQ_STATUS_ADDR) || (paddr == `SP_IRQ_ENABLE_ADDR) ||
                  (paddr == `SP_IRQ_CLEAR_ADDR) || (paddr == `SP_CFG_ADDR);

    // Bit-rate tick shared by both directions
    reg [DIV_WIDTH-1:0] tick_cnt;
    wire tick = (tick_cnt == {DIV_WIDTH{1'b0}});
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= {DIV_WIDTH{1'b0}};
        end else if (tick) begin
            tick_cnt <= divisor;
        end else begin
            tick_cnt <= tick_cnt - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Transmitter
    reg [2:0] tx_state;
    reg [8:0] tx_shift;
    reg [3:0] tx_count;
    reg tx_done;
    reg tx_busy;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= ST_IDLE;
            tx_shift <= 9'h1FF;
            tx_count <= 4'h0;
            tx_done <= 1'b0;
            tx_busy <= 1'b0;
            txd <= 1'b1;
        end else begin
            tx_done <= 1'b0;
            case (tx_state)
                ST_IDLE: begin
                    txd <= 1'b1;
                    if (tx_busy && tick) begin
                        txd <= 1'b0;
                        tx_count <= 4'h0;
                        tx_state <= ST_DATA;
                    end else if (wr_data && !tx_busy) begin
                        // A write while busy only flags a collision, the frame is kept
                        // Ninth bit sampled only in nine-bit modes
                        tx_shift <= {nine_bit ? serial_control[`CTRL_TB8] : 1'b1,
                                     pwdata[7:0]};
                        tx_busy <= 1'b1;
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        txd <= tx_shift[0];
                        tx_shift <= {1'b1, tx_shift[8:1]};
                        tx_count <= tx_count + 4'h1;
                        if (tx_count + 4'h1 == frame_bits) begin
                            tx_state <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        txd <= 1'b1;
                        tx_done <= 1'b1;
                        tx_busy <= 1'b0;
                        tx_state <= ST_IDLE;
                    end
                end
                default: begin
                    tx_state <= ST_IDLE;
                end
            endcase
        end
    end

    // Receiver, sampled at bit ticks; line assumed aligned to the tick grid
    reg [2:0] rx_state;
    reg [8:0] rx_shift;
    reg [3:0] rx_count;
    reg rx_load;
    reg rx_flag_set;
    reg rx_fe_set;
    reg rx_ninth;
    wire [8:0] rx_word;
    wire [8:0] rx_shifted = {rxd, rx_shift[8:1]};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= ST_IDLE;
            rx_shift <= 9'h000;
            rx_count <= 4'h0;
            rx_load <= 1'b0;
            rx_flag_set <= 1'b0;
            rx_fe_set <= 1'b0;
            rx_ninth <= 1'b0;
        end else begin
            rx_load <= 1'b0;
            rx_flag_set <= 1'b0;
            rx_fe_set <= 1'b0;
            case (rx_state)
                ST_IDLE: begin
                    if (tick && !rxd && serial_control[`CTRL_REN]) begin
                        rx_count <= 4'h0;
                        rx_state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        rx_shift <= rx_shifted;
                        rx_count <= rx_count + 4'h1;
                        if (rx_count + 4'h1 == frame_bits) begin
                            rx_state <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        rx_state <= ST_IDLE;
                        // Receiver disabled mid-frame drops the frame
                        if (serial_control[`CTRL_REN]) begin
                            rx_fe_set <= !rxd;
                            rx_ninth <= nine_bit ? rx_shift[8] : rxd;
                            rx_load <= 1'b1;
                            if (mode == `MODE_8BIT && serial_control[`CTRL_MPSC]) begin
                                rx_flag_set <= rxd;
                            end else if (nine_bit && serial_control[`CTRL_MPSC]) begin
                                rx_flag_set <= rx_shift[8];
                            end else begin
                                rx_flag_set <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    rx_state <= ST_IDLE;
                end
            endcase
        end
    end

    serial_rx_buffer #(
        .WIDTH(9)
    ) u_rx_buffer (
        .pclk(pclk),
        .presetn(presetn),
        .load(rx_load),
        .wdata({rx_ninth, nine_bit ? rx_shift[7:0] : rx_shift[8:1]}),
        .rdata(rx_word)
    );

    // Control and status registers; hardware set wins over software write
    reg rx_unread;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control <= `SP_CTRL_RESET;
            serial_status_clock_select <= `SP_STAT_RESET;
            divisor <= `SP_DIVISOR_RESET;
            irq_enable <= {`IRQ_BITS{1'b0}};
            irq_status <= {`IRQ_BITS{1'b0}};
            rx_unread <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                serial_control <= pwdata[7:0];
            end
            if (wr_stat) begin
                serial_status_clock_select <= pwdata[7:0];
            end
            if (wr_div) begin
                divisor <= pwdata[DIV_WIDTH-1:0];
            end
            if (wr_ien) begin
                irq_enable <= pwdata[`IRQ_BITS-1:0];
            end
            if (wr_data && tx_busy) begin
                serial_status_clock_select[`STAT_TXCOL] <= 1'b1;
            end
            if (rd_data) begin
                rx_unread <= 1'b0;
            end
            if (rx_load) begin
                serial_control[`CTRL_RB8] <= rx_ninth;
                rx_unread <= 1'b1;
                if (rx_unread) begin
                    serial_status_clock_select[`STAT_RXOV] <= 1'b1;
                end
            end
            if (rx_flag_set) begin
                serial_control[`CTRL_RI] <= 1'b1;
            end
            if (tx_done) begin
                serial_control[`CTRL_TI] <= 1'b1;
            end
            if (rx_fe_set) begin
                serial_status_clock_select[`STAT_FE] <= 1'b1;
            end
            irq_status <= (irq_status & ~(wr_iclr ? pwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}}))
                          | {rx_fe_set, tx_done, rx_flag_set};
        end
    end

    // Interrupt: level while an enabled event or the enabled RI flag is pending
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable) ||
                   (irq_enable[`IRQ_RX] && serial_control[`CTRL_RI]);
        end
    end

    // Read data and response
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `SP_CTRL_ADDR: prdata <= {24'h00_0000, serial_control};
                    `SP_STAT_ADDR: prdata <= {24'h00_0000, serial_status_clock_select};
                    `SP_DATA_ADDR: prdata <= {23'h00_0000, rx_word};
                    `SP_DIVISOR_ADDR: prdata <= {{(32-DIV_WIDTH){1'b0}}, divisor};
                    `SP_IRQ_STATUS_ADDR: prdata <= {29'h000_0000, irq_status};
                    `SP_IRQ_ENABLE_ADDR: prdata <= {29'h000_0000, irq_enable};
                    `SP_CFG_ADDR: prdata <= {27'h000_0000, tx_busy, rx_unread,
                                             rx_state == ST_IDLE, tx_state == ST_IDLE, irq};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

//--- serial_port_defines.vh
// Register offsets, field positions, reset values and mode codes for the serial port
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

`define SP_CTRL_ADDR 12'h0090
`define SP_STAT_ADDR 12'h0091
`define SP_DATA_ADDR 12'h0099
`define SP_CFG_ADDR 12'h00A0
`define SP_IRQ_STATUS_ADDR 12'h00A4
`define SP_IRQ_ENABLE_ADDR 12'h00A8
`define SP_IRQ_CLEAR_ADDR 12'h00AC
`define SP_DIVISOR_ADDR 12'h00B0

`define SP_CTRL_RESET 8'h00
`define SP_STAT_RESET 8'h00
`define SP_DIVISOR_RESET 16'h00AE

`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_MPSC 5
`define CTRL_REN 4
`define CTRL_TB8 3
`define CTRL_RB8 2
`define CTRL_TI 1
`define CTRL_RI 0

`define STAT_FE 7
`define STAT_RXOV 6
`define STAT_TXCOL 5

`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_FE 2
`define IRQ_BITS 3

`define MODE_SYNC 2'h0
`define MODE_8BIT 2'h1
`define MODE_9FIX 2'h2
`define MODE_9VAR 2'h3

`endif

//--- serial_rx_buffer.v
// Receive holding register: latches one data byte and ninth bit on load
`timescale 1ns/1ps
module serial_rx_buffer #(
    parameter WIDTH = 9
) (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [WIDTH-1:0] wdata,
    output reg [WIDTH-1:0] rdata
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= {WIDTH{1'b0}};
        end else if (load) begin
            rdata <= wdata;
        end
    end
endmodule

//--- serial_port_props.sv
// Bus and line checker for the serial port
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire txd,
    input wire irq
);
    wire acc = psel && penable && pready;
    wire hit = paddr == `SP_CTRL_ADDR || paddr == `SP_STAT_ADDR || paddr == `SP_DATA_ADDR
        || paddr == `SP_CFG_ADDR || paddr == `SP_IRQ_STATUS_ADDR
        || paddr == `SP_IRQ_ENABLE_ADDR || paddr == `SP_IRQ_CLEAR_ADDR
        || paddr == `SP_DIVISOR_ADDR;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        acc;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> answer_s) else $error("no pready");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_unmapped_err: assert property (acc && !hit |-> pslverr) else $error("no pslverr");
    a_unmapped_zero: assert property (acc && !hit && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_err_needs_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_mapped_read_ok: assert property (acc && hit && !pwrite && paddr != `SP_IRQ_CLEAR_ADDR
        |-> !pslverr) else $error("pslverr on mapped read");
    a_reset_line_idle: assert property ($rose(presetn) |-> txd && !irq)
        else $error("not idle after reset");
endmodule

bind serial_port_zero serial_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .txd, .irq);

//--- remote_serial.sv
// Remote transceiver model: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module remote_serial #(
    parameter BIT_CYCLES = 4
) (
    input wire pclk,
    input wire txd,
    input wire nine,
    output reg rxd
);
    reg [9:0] sh;
    reg [8:0] cap_data;
    reg cap_stop;
    integer frames = 0;
    integer i;
    initial rxd = 1'b1;
    // Whole bit periods keep each bit across exactly one receiver tick
    task send(input [8:0] bits, input integer nbits, input stop);
        integer k;
        begin
            for (k = -1; k <= nbits; k = k + 1) begin
                @(posedge pclk);
                rxd <= (k < 0) ? 1'b0 : (k == nbits) ? stop : bits[k];
                repeat (BIT_CYCLES - 1) @(posedge pclk);
            end
            @(posedge pclk);
            rxd <= 1'b1;
        end
    endtask
    // Sample mid-bit, LSB first, stop last
    always @(negedge txd) begin
        sh = 10'h000;
        repeat (BIT_CYCLES / 2) @(posedge pclk);
        for (i = 0; i < 9 + nine; i = i + 1) begin
            repeat (BIT_CYCLES) @(posedge pclk);
            sh[i] = txd;
        end
        cap_data = nine ? sh[8:0] : {1'b0, sh[7:0]};
        cap_stop = nine ? sh[9] : sh[8];
        frames = frames + 1;
    end
endmodule

//--- serial_port_control_status_test.sv
// Register-level test of the serial port control and status bits
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_control_status_test;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000;
    reg nine = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, rxd, txd, irq;
    reg [31:0] rd;
    reg err;
    reg [7:0] tctl [0:2];
    integer failures = 0;
    integer samples_checked = 0;
    integer n, j, f, nf;
    serial_port_zero DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    remote_serial partner (.pclk(pclk), .txd(txd), .nine(nine), .rxd(rxd));
    initial forever #25 pclk = ~pclk;
    task results;
        begin
            $display("checked %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task check(input string name, input [31:0] exp, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value %s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task stop_if(input bad);
        if (bad) begin
            failures = failures + 1;
            results;
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            stop_if(pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Polling keeps the bus busy, so the flag is seen through software's view
    task wait_bit(input [11:0] a, input integer b);
        begin
            rd = 0;
            for (j = 0; j < 100 && rd[b] !== 1'b1; j = j + 1) apb(0, a, 0);
            stop_if(rd[b] !== 1'b1);
        end
    endtask
    initial begin
        tctl[0] = {`MODE_9VAR, 6'h08};
        tctl[1] = {`MODE_8BIT, 6'h08};
        tctl[2] = {`MODE_SYNC, 6'h08};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SP_CTRL_ADDR, 0);
        check("ctrl reset", `SP_CTRL_RESET, rd);
        apb(0, `SP_STAT_ADDR, 0);
        check("stat reset", `SP_STAT_RESET, rd);
        apb(0, 12'h0FF0, 0);
        check("unmapped err", 1, err);
        $display("test reset_bus done");
        apb(1, `SP_DIVISOR_ADDR, 32'h0000_0003);
        // The reset-rate count must run out before the new rate applies
        repeat (200) @(posedge pclk);
        apb(1, `SP_IRQ_ENABLE_ADDR, 32'h0000_0001);
        apb(1, `SP_CTRL_ADDR, {`MODE_8BIT, 6'h00});
        partner.send(9'h0A5, 8, 1);
        apb(0, `SP_CTRL_ADDR, 0);
        check("ri when off", 0, rd[0]);
        $display("test rx_disabled done");
        apb(1, `SP_CTRL_ADDR, {`MODE_8BIT, 6'h10});
        partner.send(9'h0A5, 8, 1);
        wait_bit(`SP_CTRL_ADDR, 0);
        check("irq on ri", 1, irq);
        apb(0, `SP_DATA_ADDR, 0);
        check("rx byte", 8'hA5, rd[7:0]);
        apb(1, `SP_IRQ_ENABLE_ADDR, 0);
        repeat (2) @(posedge pclk);
        check("irq masked", 0, irq);
        apb(1, `SP_CTRL_ADDR, {`MODE_8BIT, 6'h10});
        apb(1, `SP_IRQ_CLEAR_ADDR, 32'h0000_0007);
        apb(1, `SP_IRQ_ENABLE_ADDR, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check("irq cleared", 0, irq);
        $display("test rx_irq done");
        apb(1, `SP_CTRL_ADDR, {`MODE_8BIT, 6'h30});
        partner.send(9'h05A, 8, 0);
        repeat (8) @(posedge pclk);
        apb(0, `SP_CTRL_ADDR, 0);
        check("ri bad stop", 0, rd[0]);
        apb(0, `SP_STAT_ADDR, 0);
        check("frame error", 1, rd[`STAT_FE]);
        $display("test stop_check done");
        apb(1, `SP_CTRL_ADDR, {`MODE_9VAR, 6'h10});
        partner.send(9'h15A, 9, 1);
        wait_bit(`SP_CTRL_ADDR, 0);
        check("rx ninth", 1, rd[`CTRL_RB8]);
        apb(0, `SP_DATA_ADDR, 0);
        check("rx nine word", 9'h15A, rd[8:0]);
        apb(1, `SP_CTRL_ADDR, {`MODE_9VAR, 6'h30});
        partner.send(9'h05A, 9, 1);
        repeat (8) @(posedge pclk);
        apb(0, `SP_CTRL_ADDR, 0);
        check("ri ninth low", 0, rd[0]);
        $display("test rx_nine done");
        for (f = 0; f < 3; f = f + 1) begin
            nine <= (f == 0);
            apb(1, `SP_CTRL_ADDR, tctl[f]);
            nf = partner.frames;
            apb(1, `SP_DATA_ADDR, 32'h0000_00C3);
            wait_bit(`SP_CTRL_ADDR, 1);
            for (j = 0; j < 200 && partner.frames == nf; j = j + 1) @(posedge pclk);
            stop_if(partner.frames == nf);
            check("tx frame", (f == 0) ? 9'h1C3 : 9'h0C3, partner.cap_data);
            check("tx stop", 1, partner.cap_stop);
            apb(0, `SP_CTRL_ADDR, 0);
            check("ti sticky", 1, rd[1]);
        end
        $display("test tx_ninth done");
        results;
    end
endmodule
